// File: sim/peer_relay_model.sv
`timescale 1ns/1ps
module peer_relay_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [3:0]  src,
    input  wire logic [31:0] bits,
    input  wire logic [17:0] hold,
    output logic             rx_valid,
    output logic      [3:0]  rx_src,
    output logic      [31:0] rx_bits,
    output logic      [17:0] rx_hold
);
    // Between messages the fields are inverted so a receiver that samples them late sees wrong data.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_valid <= 1'b0;
            rx_src   <= 4'h0;
            rx_bits  <= 32'h0;
            rx_hold  <= 18'h0;
        end
        else
        begin
            rx_valid <= go;
            rx_src   <= go ? src : ~rx_src;
            rx_bits  <= go ? bits : ~rx_bits;
            rx_hold  <= go ? hold : ~rx_hold;
        end
    end
endmodule

// File: sim/test_relay_point_exchange.sv
`timescale 1ns/1ps
module test_relay_point_exchange;
    logic         CLK, SYS_RST, HSEL, HWRITE, BTN_RESET_PIN, LINK_RESET, go;
    logic [31:0]  HADDR, HWDATA, m_bits;
    logic [1:0]   HTRANS, ctrl;
    logic [2:0]   HSIZE;
    logic [63:0]  LOGIC_SIG, sig;
    logic [3:0]   BKR_DS, bkr, m_src;
    logic [15:0]  IND_COND, ivl, lat_exp;
    logic [17:0]  m_hold;
    wire logic    HREADY, RX_VALID;
    wire logic [3:0]  RX_SRC;
    wire logic [31:0] RX_BITS;
    wire logic [17:0] RX_HOLD;
    logic [31:0]  HRDATA, TX_USER, TX_PREDEF, TX_DIRECT, DIRECT_IN;
    logic         HREADYOUT, HRESP, TX_SEND, RESET_OPERATE, RESET_FROM_BUTTON, RESET_FROM_LINK, RESET_FROM_LOGIC;
    logic [17:0]  TX_HOLD;
    logic [15:0]  SRC_OFFLINE, IND_LATCH;
    logic [5:0]   usel[32], psel[32], dsel[32];
    logic [31:0]  q_rd[$];
    logic [113:0] q_tx[$];
    logic [19:0]  q_rst[$], rn;
    logic         pend, lat_chk;
    int           fail_count, tests_run, cycles, n;

    assign HREADY = HREADYOUT;

    relay_point_exchange #(.TICK_CYCLES(10)) relay_point_exchange_i (
        .CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
        .HRESP, .LOGIC_SIG, .BKR_DS, .RX_VALID, .RX_SRC, .RX_BITS, .RX_HOLD, .BTN_RESET_PIN, .LINK_RESET,
        .IND_COND, .TX_SEND, .TX_USER, .TX_PREDEF, .TX_DIRECT, .TX_HOLD, .DIRECT_IN, .SRC_OFFLINE,
        .RESET_OPERATE, .RESET_FROM_BUTTON, .RESET_FROM_LINK, .RESET_FROM_LOGIC, .IND_LATCH
    );

    peer_relay_model peer_relay_model_i (
        .clk(CLK), .rst(SYS_RST), .go, .src(m_src), .bits(m_bits), .hold(m_hold),
        .rx_valid(RX_VALID), .rx_src(RX_SRC), .rx_bits(RX_BITS), .rx_hold(RX_HOLD)
    );

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task cmp(input logic [113:0] e, input logic [113:0] a);
        tests_run++;
        if (e !== a)
        begin
            fail_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task close_out;
        fail_count += q_rd.size() + q_tx.size() + q_rst.size();
        $display("compares=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A write is followed by an idle edge so a read right after it never overlaps its data phase.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= {20'h0, a};
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        if (w)
            @(posedge CLK);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task msg(input logic [3:0] s, input logic [31:0] b, input logic [17:0] h);
        go     <= 1'b1;
        m_src  <= s;
        m_bits <= b;
        m_hold <= h;
        @(posedge CLK);
        go <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask

    function automatic logic [113:0] tx_exp();
        logic [31:0] u, p, d;
        for (int i = 0; i < 32; i++)
        begin
            u[i] = sig[usel[i]];
            p[i] = sig[psel[i]];
            d[i] = sig[dsel[i]];
        end
        p[20]    = ctrl[0];
        p[26]    = ctrl[1];
        p[16:13] = bkr;
        p[31:27] = 5'h0;
        return {18'(3 * ivl), d, p, u};
    endfunction

    always @(posedge CLK)
    begin
        if (pend && q_rd.size() > 0)
            cmp(114'({1'b0, q_rd.pop_front()}), 114'({HRESP, HRDATA}));
        if (HREADYOUT)
            pend <= HSEL & HTRANS[1] & ~HWRITE;
        if (TX_SEND === 1'b1 && q_tx.size() > 0)
            cmp(q_tx.pop_front(), {TX_HOLD, TX_DIRECT, TX_PREDEF, TX_USER});
        lat_chk <= 1'b0;
        if (lat_chk)
            cmp(114'(lat_exp), 114'(IND_LATCH));
        if (RESET_OPERATE === 1'b1 && q_rst.size() > 0)
        begin
            rn = q_rst.pop_front();
            cmp(114'(rn[19:16]), 114'({RESET_OPERATE, RESET_FROM_BUTTON, RESET_FROM_LINK, RESET_FROM_LOGIC}));
            lat_exp <= rn[15:0];
            lat_chk <= 1'b1;
        end
    end

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out;
        end
    end

    initial
    begin
        {SYS_RST, HSEL, HWRITE, HADDR, HWDATA, HTRANS, HSIZE} = {1'b1, 68'h0, 3'h2};
        {BTN_RESET_PIN, LINK_RESET, go, m_src, m_bits, m_hold, LOGIC_SIG, BKR_DS, IND_COND} = '0;
        {sig, bkr, pend, lat_chk, ctrl, ivl} = {70'h0, 2'h1, 16'h03e8};
        {fail_count, tests_run, cycles} = '0;
        for (int i = 0; i < 32; i++)
            {usel[i], psel[i], dsel[i]} = '0;
        void'($urandom(2));
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rd(12'h000, 32'h1);
        rd(12'h004, 32'h3e8);
        rd(12'h00c, 32'hffff);
        rd(12'hff0, 32'h0);
        $display("test registers done");
        ivl = 16'd50;
        bus(1'b1, 12'h004, 32'd50);
        usel[3] = 6'h07;
        bus(1'b1, 12'h10c, 32'h7);
        psel[4] = 6'h09;
        bus(1'b1, 12'h190, 32'h9);
        dsel[0] = 6'h07;
        bus(1'b1, 12'h200, 32'h7);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 2)
            begin
                ctrl = 2'h2;
                bus(1'b1, 12'h000, 32'h2);
            end
            repeat (3) @(posedge CLK);
            sig = {$urandom, $urandom} ^ 64'h80;
            sig[7] = ~LOGIC_SIG[7];
            bkr = 4'($urandom);
            LOGIC_SIG <= sig;
            BKR_DS <= bkr;
            q_tx.push_back(tx_exp());
        end
        repeat (3) @(posedge CLK);
        $display("test transmit done");
        ivl = 16'd2;
        bus(1'b1, 12'h004, 32'h2);
        n = 0;
        repeat (200)
        begin
            @(posedge CLK);
            n += int'(TX_SEND);
        end
        cmp(114'(n >= 9 && n <= 20), 114'(1));
        $display("test periodic done");
        bus(1'b1, 12'h300, 32'h642);
        bus(1'b1, 12'h304, 32'h252);
        bus(1'b1, 12'h308, 32'h003);
        bus(1'b1, 12'h30c, 32'h413);
        rd(12'h010, 32'h3);
        msg(4'h2, 32'h0, 18'h3);
        rd(12'h00c, 32'hfffb);
        rd(12'h010, 32'h0);
        repeat (60) @(posedge CLK);
        rd(12'h010, 32'h2);
        rd(12'h00c, 32'hffff);
        msg(4'h2, 32'h10, 18'h3);
        rd(12'h010, 32'h1);
        msg(4'h3, 32'hffffffff, 18'h0);
        rd(12'h00c, 32'hfffb);
        $display("test receive done");
        bus(1'b1, 12'h008, 32'hb);
        for (int k = 0; k < 3; k++)
        begin
            IND_COND <= 16'h00ff;
            @(posedge CLK);
            IND_COND <= 16'h000f;
            repeat (3) @(posedge CLK);
            cmp(114'(16'h00ff), 114'(IND_LATCH));
            q_rst.push_back({4'b1000 | (4'b0100 >> k), 16'h000f});
            BTN_RESET_PIN <= (k == 0);
            LINK_RESET <= (k == 1);
            sig[11] = (k == 2);
            LOGIC_SIG <= sig;
            @(posedge CLK);
            LINK_RESET <= 1'b0;
            repeat (10) @(posedge CLK);
            BTN_RESET_PIN <= 1'b0;
            sig[11] = 1'b0;
            LOGIC_SIG <= sig;
            repeat (8) @(posedge CLK);
        end
        $display("test reset unit done");
        close_out;
    end
endmodule

// File: src/latch_reset_unit.sv
`timescale 1ns/1ps
module latch_reset_unit #(
    parameter int N = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         btn_pin,
    input  wire logic         link_req,
    input  wire logic         logic_lvl,
    input  wire logic [N-1:0] cond,
    output logic              reset_operate,
    output logic              from_button,
    output logic              from_link,
    output logic              from_logic,
    output logic [N-1:0]      latch
);

    typedef struct packed {
        logic [2:0]   sync;
        logic         btn_lvl;
        logic         logic_prev;
        logic         op;
        logic         btn;
        logic         lnk;
        logic         lgc;
        logic [N-1:0] latch;
    } unit_s;

    unit_s unit_ff;
    unit_s nxt_unit;
    logic  btn_rise;
    logic  logic_rise;

    always_comb
    begin
        nxt_unit = unit_ff;
        nxt_unit.sync = {unit_ff.sync[1:0], btn_pin};
        btn_rise = (unit_ff.sync[1] == unit_ff.sync[2]) && unit_ff.sync[1] && !unit_ff.btn_lvl;
        if (unit_ff.sync[1] == unit_ff.sync[2])
        begin
            nxt_unit.btn_lvl = unit_ff.sync[1];
        end
        logic_rise = logic_lvl && !unit_ff.logic_prev;
        nxt_unit.logic_prev = logic_lvl;
        nxt_unit.btn = btn_rise; // R16
        nxt_unit.lnk = link_req; // R16
        nxt_unit.lgc = logic_rise; // R16
        nxt_unit.op = btn_rise || link_req || logic_rise; // R15
        // A latch whose condition is still present is set again, so only cleared ones drop.
        nxt_unit.latch = cond | (unit_ff.latch & ~{N{unit_ff.op}}); // R13 R14
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            unit_ff <= '0;
        end
        else
        begin
            unit_ff <= nxt_unit;
        end
    end

    assign reset_operate = unit_ff.op;
    assign from_button   = unit_ff.btn;
    assign from_link     = unit_ff.lnk;
    assign from_logic    = unit_ff.lgc;
    assign latch         = unit_ff.latch;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_common;
        (btn_rise || link_req || logic_rise) |=> reset_operate;
    endproperty
    a_common: assert property (p_common) else $error("reset source without common reset"); // R15

    property p_source;
        link_req |=> (from_link && reset_operate && !from_button) or (from_link && reset_operate && $past(btn_rise));
    endproperty
    a_source: assert property (p_source) else $error("link reset not identified"); // R16

    property p_clear;
        reset_operate && !cond[4] |=> !latch[4];
    endproperty
    a_clear: assert property (p_clear) else $error("cleared latch not reset"); // R14

    property p_hold;
        latch[4] && !reset_operate ##1 !reset_operate |=> latch[4];
    endproperty
    a_hold: assert property (p_hold) else $error("latch dropped without reset"); // R13

endmodule

// File: src/relay_point_exchange.sv
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// R1: 32 remote points carry selected logic signals.
// R2: user status pairs send user-selected signal.
// R3: pair 21 sends offline or available.
// R4: pair 27 sends normal or test mode.
// R5: pairs 14-17 send breaker open/closed state.
// R6: command pairs read one when asserted.
// R7: resend periodically after configurable interval.
// R8: direct input takes configured bit from source.
// R9: offline source forces on/off default value.
// R10: latest modes freeze; unknown gives on/off.
// R11: resumed link makes input follow again.
// R12: direct output sends its selected signal.
// R13: indicator latches hold until reset command.
// R14: reset clears only cleared latches; events logged (no event log is kept here).
// R15: three reset sources assert common reset.
// R16: each source asserts its own reset.
// R17: setting selects logic reset signal.
// R18: hold time is three times interval.
// R19: per-source hold timer declares source offline.
// R20: offline flag selects received bit or default.
// R21: pairs 28-32 are reserved, send zero.
module relay_point_exchange #(
    parameter int TICK_CYCLES = rpx_pkg::TICK_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [63:0] LOGIC_SIG,
    input  wire logic [3:0]  BKR_DS,
    input  wire logic        RX_VALID,
    input  wire logic [3:0]  RX_SRC,
    input  wire logic [31:0] RX_BITS,
    input  wire logic [17:0] RX_HOLD,
    input  wire logic        BTN_RESET_PIN,
    input  wire logic        LINK_RESET,
    input  wire logic [15:0] IND_COND,
    output logic             TX_SEND,
    output logic      [31:0] TX_USER,
    output logic      [31:0] TX_PREDEF,
    output logic      [31:0] TX_DIRECT,
    output logic      [17:0] TX_HOLD,
    output logic      [31:0] DIRECT_IN,
    output logic      [15:0] SRC_OFFLINE,
    output logic             RESET_OPERATE,
    output logic             RESET_FROM_BUTTON,
    output logic             RESET_FROM_LINK,
    output logic             RESET_FROM_LOGIC,
    output logic      [15:0] IND_LATCH
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [31:0][5:0]  user_sel;
        logic [31:0][5:0]  pre_sel;
        logic [31:0][5:0]  dout_sel;
        logic [31:0][10:0] di_cfg;
        logic [1:0]        ctrl;
        logic [15:0]       interval;
        logic [5:0]        rst_sel;
        logic              a_act;
        logic              a_wr;
        logic [11:0]       a_addr;
        logic [31:0]       rdata;
        logic [TW-1:0]     tick_cnt;
        logic [15:0]       upd_cnt;
        logic              sent_once;
        logic [31:0]       tx_user;
        logic [31:0]       tx_pre;
        logic [31:0]       tx_dout;
        logic              tx_send;
        logic [17:0]       tx_hold;
        logic [15:0][17:0] hold_tmr;
        logic [15:0]       offline;
        logic [31:0]       di_val;
        logic [31:0]       di_known;
        logic [31:0]       di_out;
    } state_s;

    state_s      st_ff;
    state_s      nxt_st;
    logic        take;
    logic        tick;
    logic        periodic;
    logic        changed;
    logic        logic_reset;
    logic [31:0] rd;
    logic [31:0] usr;
    logic [31:0] pre;
    logic [31:0] dout;
    logic [3:0]  src;
    logic [4:0]  bitn;

    function automatic logic pick(input logic [63:0] sig, input logic [5:0] idx);
        return sig[idx];
    endfunction

    function automatic logic tbl_hit(input logic [11:0] addr, input logic [11:0] base);
        return addr[11:7] == base[11:7];
    endfunction

    always_comb
    begin
        nxt_st = st_ff;

        // Bus address phase; read data is fetched here so it stands through the data phase.
        take = HSEL && HTRANS[1] && HREADY;
        nxt_st.a_act = take;
        nxt_st.a_wr = HWRITE;
        nxt_st.a_addr = HADDR[11:0];
        rd = 32'h00000000;
        if (tbl_hit(HADDR[11:0], rpx_pkg::USER_SEL_BASE))
        begin
            rd[5:0] = st_ff.user_sel[HADDR[6:2]];
        end
        else if (tbl_hit(HADDR[11:0], rpx_pkg::PRE_SEL_BASE))
        begin
            rd[5:0] = st_ff.pre_sel[HADDR[6:2]];
        end
        else if (tbl_hit(HADDR[11:0], rpx_pkg::DOUT_SEL_BASE))
        begin
            rd[5:0] = st_ff.dout_sel[HADDR[6:2]];
        end
        else if (tbl_hit(HADDR[11:0], rpx_pkg::DI_CFG_BASE))
        begin
            rd[10:0] = st_ff.di_cfg[HADDR[6:2]];
        end
        else if (HADDR[11:0] == rpx_pkg::CTRL_OFS)
        begin
            rd[1:0] = st_ff.ctrl;
        end
        else if (HADDR[11:0] == rpx_pkg::INTERVAL_OFS)
        begin
            rd[15:0] = st_ff.interval;
        end
        else if (HADDR[11:0] == rpx_pkg::RST_SEL_OFS)
        begin
            rd[5:0] = st_ff.rst_sel;
        end
        else if (HADDR[11:0] == rpx_pkg::OFFLINE_OFS)
        begin
            rd[15:0] = st_ff.offline;
        end
        else if (HADDR[11:0] == rpx_pkg::DIRECT_IN_OFS)
        begin
            rd = st_ff.di_out;
        end
        nxt_st.rdata = (take && !HWRITE) ? rd : 32'h00000000;

        // Bus data phase of a write; unmapped addresses are ignored.
        if (st_ff.a_act && st_ff.a_wr)
        begin
            if (tbl_hit(st_ff.a_addr, rpx_pkg::USER_SEL_BASE))
            begin
                nxt_st.user_sel[st_ff.a_addr[6:2]] = HWDATA[5:0];
            end
            else if (tbl_hit(st_ff.a_addr, rpx_pkg::PRE_SEL_BASE))
            begin
                nxt_st.pre_sel[st_ff.a_addr[6:2]] = HWDATA[5:0];
            end
            else if (tbl_hit(st_ff.a_addr, rpx_pkg::DOUT_SEL_BASE))
            begin
                nxt_st.dout_sel[st_ff.a_addr[6:2]] = HWDATA[5:0];
            end
            else if (tbl_hit(st_ff.a_addr, rpx_pkg::DI_CFG_BASE))
            begin
                nxt_st.di_cfg[st_ff.a_addr[6:2]] = HWDATA[10:0];
            end
            else if (st_ff.a_addr == rpx_pkg::CTRL_OFS)
            begin
                nxt_st.ctrl = HWDATA[1:0];
            end
            else if (st_ff.a_addr == rpx_pkg::INTERVAL_OFS)
            begin
                nxt_st.interval = HWDATA[15:0];
            end
            else if (st_ff.a_addr == rpx_pkg::RST_SEL_OFS)
            begin
                nxt_st.rst_sel = HWDATA[5:0];
            end
        end

        // Millisecond tick shared by the send interval and the hold timers.
        tick = (st_ff.tick_cnt == TW'(TICK_CYCLES - 1));
        nxt_st.tick_cnt = tick ? '0 : TW'(st_ff.tick_cnt + 1'b1);

        // Outgoing points.
        for (int i = 0; i < rpx_pkg::NUM_POINTS; i++)
        begin
            usr[i] = pick(LOGIC_SIG, st_ff.user_sel[i]); // R1 R2
            pre[i] = pick(LOGIC_SIG, st_ff.pre_sel[i]); // R6
            dout[i] = pick(LOGIC_SIG, st_ff.dout_sel[i]); // R12
        end
        pre[rpx_pkg::PAIR_STATUS] = st_ff.ctrl[rpx_pkg::CTRL_AVAIL_BIT]; // R3
        pre[rpx_pkg::PAIR_MODE] = st_ff.ctrl[rpx_pkg::CTRL_TEST_BIT]; // R4
        pre[rpx_pkg::PAIR_BKR_LO +: 4] = BKR_DS; // R5
        pre[31:rpx_pkg::PAIR_RSV_LO] = '0; // R21
        changed = (usr != st_ff.tx_user) || (pre != st_ff.tx_pre) || (dout != st_ff.tx_dout);
        periodic = tick && (st_ff.interval != 16'h0000) && (17'(st_ff.upd_cnt) + 17'h1 >= 17'(st_ff.interval)); // R7
        nxt_st.tx_send = changed || periodic || !st_ff.sent_once; // R7
        nxt_st.sent_once = 1'b1;
        nxt_st.tx_user = usr;
        nxt_st.tx_pre = pre;
        nxt_st.tx_dout = dout;
        if (nxt_st.tx_send)
        begin
            nxt_st.upd_cnt = 16'h0000;
        end
        else if (tick)
        begin
            nxt_st.upd_cnt = 16'(st_ff.upd_cnt + 1'b1);
        end
        nxt_st.tx_hold = 18'(st_ff.interval * rpx_pkg::HOLD_FACTOR); // R18

        // Per-source hold timers; a source is offline once its timer has run out.
        for (int k = 0; k < rpx_pkg::NUM_SOURCES; k++)
        begin
            if (RX_VALID && RX_SRC == 4'(k))
            begin
                nxt_st.hold_tmr[k] = RX_HOLD; // R19
            end
            else if (tick && st_ff.hold_tmr[k] != 18'h00000)
            begin
                nxt_st.hold_tmr[k] = 18'(st_ff.hold_tmr[k] - 1'b1); // R19
            end
            nxt_st.offline[k] = (st_ff.hold_tmr[k] == 18'h00000); // R19 R20
        end

        // Direct inputs.
        src = 4'h0;
        bitn = 5'h00;
        for (int i = 0; i < rpx_pkg::NUM_POINTS; i++)
        begin
            src = st_ff.di_cfg[i][rpx_pkg::DI_SRC_LO +: rpx_pkg::SRC_W];
            bitn = st_ff.di_cfg[i][rpx_pkg::DI_BIT_LO +: rpx_pkg::BIT_W];
            if (RX_VALID && RX_SRC == src)
            begin
                nxt_st.di_val[i] = RX_BITS[bitn]; // R8
                nxt_st.di_known[i] = 1'b1;
            end
            if (!st_ff.offline[src])
            begin
                nxt_st.di_out[i] = st_ff.di_val[i]; // R11 R20
            end
            else
            begin
                unique case (st_ff.di_cfg[i][rpx_pkg::DI_MODE_LO +: 2])
                    rpx_pkg::DEF_OFF:        nxt_st.di_out[i] = 1'b0; // R9
                    rpx_pkg::DEF_ON:         nxt_st.di_out[i] = 1'b1; // R9
                    rpx_pkg::DEF_LATEST_OFF: nxt_st.di_out[i] = st_ff.di_known[i] && st_ff.di_val[i]; // R10
                    rpx_pkg::DEF_LATEST_ON:  nxt_st.di_out[i] = !st_ff.di_known[i] || st_ff.di_val[i]; // R10
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_ff          <= '0;
            st_ff.user_sel <= {rpx_pkg::NUM_POINTS{rpx_pkg::SEL_RST}};
            st_ff.pre_sel  <= {rpx_pkg::NUM_POINTS{rpx_pkg::SEL_RST}};
            st_ff.dout_sel <= {rpx_pkg::NUM_POINTS{rpx_pkg::SEL_RST}};
            st_ff.di_cfg   <= {rpx_pkg::NUM_POINTS{rpx_pkg::DI_CFG_RST}};
            st_ff.ctrl     <= rpx_pkg::CTRL_RST;
            st_ff.interval <= rpx_pkg::INTERVAL_RST;
            st_ff.rst_sel  <= rpx_pkg::SEL_RST;
            st_ff.offline  <= '1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign logic_reset = pick(LOGIC_SIG, st_ff.rst_sel); // R17

    latch_reset_unit #(
        .N (rpx_pkg::NUM_LATCHES)
    ) u_reset (
        .clk           (CLK),
        .rst           (SYS_RST),
        .btn_pin       (BTN_RESET_PIN),
        .link_req      (LINK_RESET),
        .logic_lvl     (logic_reset),
        .cond          (IND_COND),
        .reset_operate (RESET_OPERATE),
        .from_button   (RESET_FROM_BUTTON),
        .from_link     (RESET_FROM_LINK),
        .from_logic    (RESET_FROM_LOGIC),
        .latch         (IND_LATCH)
    );

    assign HRDATA      = st_ff.rdata;
    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign TX_SEND     = st_ff.tx_send;
    assign TX_USER     = st_ff.tx_user;
    assign TX_PREDEF   = st_ff.tx_pre;
    assign TX_DIRECT   = st_ff.tx_dout;
    assign TX_HOLD     = st_ff.tx_hold;
    assign DIRECT_IN   = st_ff.di_out;
    assign SRC_OFFLINE = st_ff.offline;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_user_pt;
        !$past(SYS_RST) |-> ##1 TX_USER[0] == $past(LOGIC_SIG[st_ff.user_sel[0]]);
    endproperty
    a_user_pt: assert property (p_user_pt) else $error("user point does not follow its signal"); // R1

    property p_dout_pt;
        !$past(SYS_RST) |-> ##1 TX_DIRECT[31] == $past(LOGIC_SIG[st_ff.dout_sel[31]]);
    endproperty
    a_dout_pt: assert property (p_dout_pt) else $error("direct output does not follow its signal"); // R12

    property p_status_pair;
        !SYS_RST |=> TX_PREDEF[20] == $past(st_ff.ctrl[0]);
    endproperty
    a_status_pair: assert property (p_status_pair) else $error("status pair wrong"); // R3

    property p_mode_pair;
        !SYS_RST |=> TX_PREDEF[26] == $past(st_ff.ctrl[1]);
    endproperty
    a_mode_pair: assert property (p_mode_pair) else $error("mode pair wrong"); // R4

    property p_bkr_pair;
        !SYS_RST |=> TX_PREDEF[16:13] == $past(BKR_DS);
    endproperty
    a_bkr_pair: assert property (p_bkr_pair) else $error("breaker pairs wrong"); // R5

    property p_reserved;
        TX_PREDEF[31:27] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved pairs not zero"); // R21

    property p_periodic;
        periodic |=> TX_SEND;
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic message missing"); // R7

    property p_change_send;
        !SYS_RST && changed |=> TX_SEND && TX_USER == $past(usr) && TX_PREDEF == $past(pre) && TX_DIRECT == $past(dout);
    endproperty
    a_change_send: assert property (p_change_send) else $error("change not sent"); // R7

    property p_hold_time;
        TX_SEND |-> TX_HOLD == 18'($past(st_ff.interval) * 3);
    endproperty
    a_hold_time: assert property (p_hold_time) else $error("hold time not three intervals"); // R18

    property p_default_on;
        SRC_OFFLINE[st_ff.di_cfg[1][3:0]] && st_ff.di_cfg[1][10:9] == 2'h1 |=> DIRECT_IN[1];
    endproperty
    a_default_on: assert property (p_default_on) else $error("offline input not forced on"); // R9

    sequence s_msg0;
        RX_VALID && RX_SRC == st_ff.di_cfg[0][3:0] && RX_HOLD > 18'h00001 && $stable(st_ff.di_cfg[0]);
    endsequence

    sequence s_quiet;
        !RX_VALID && $stable(st_ff.di_cfg[0]);
    endsequence

    property p_follow;
        logic b;
        (s_msg0, b = RX_BITS[st_ff.di_cfg[0][8:4]]) ##1 s_quiet ##1 s_quiet |=> DIRECT_IN[0] == b;
    endproperty
    a_follow: assert property (p_follow) else $error("direct input does not follow message"); // R8 R11

    property p_expire;
        tick && st_ff.hold_tmr[2] == 18'h00001 && !(RX_VALID && RX_SRC == 4'h2) |=> ##1 SRC_OFFLINE[2];
    endproperty
    a_expire: assert property (p_expire) else $error("source not declared offline"); // R19

endmodule

// File: src/rpx_pkg.sv
package rpx_pkg;

    // Clock and timer base.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sizes.
    localparam int NUM_POINTS  = 32;
    localparam int NUM_SIGNALS = 64;
    localparam int NUM_SOURCES = 16;
    localparam int NUM_LATCHES = 16;
    localparam int SEL_W       = 6;
    localparam int SRC_W       = 4;
    localparam int BIT_W       = 5;
    localparam int IVL_W       = 16;
    localparam int HOLD_W      = 18;
    localparam int DI_CFG_W    = 11;
    localparam int HOLD_FACTOR = 3;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] INTERVAL_OFS  = 12'h004;
    localparam logic [11:0] RST_SEL_OFS   = 12'h008;
    localparam logic [11:0] OFFLINE_OFS   = 12'h00c;
    localparam logic [11:0] DIRECT_IN_OFS = 12'h010;
    localparam logic [11:0] USER_SEL_BASE = 12'h100;
    localparam logic [11:0] PRE_SEL_BASE  = 12'h180;
    localparam logic [11:0] DOUT_SEL_BASE = 12'h200;
    localparam logic [11:0] DI_CFG_BASE   = 12'h300;

    // Control fields.
    localparam int CTRL_AVAIL_BIT = 0;
    localparam int CTRL_TEST_BIT  = 1;

    // Direct input configuration fields.
    localparam int DI_SRC_LO  = 0;
    localparam int DI_BIT_LO  = 4;
    localparam int DI_MODE_LO = 9;

    // Direct input default modes.
    localparam logic [1:0] DEF_OFF        = 2'h0;
    localparam logic [1:0] DEF_ON         = 2'h1;
    localparam logic [1:0] DEF_LATEST_OFF = 2'h2;
    localparam logic [1:0] DEF_LATEST_ON  = 2'h3;

    // Predefined status pair positions, zero based.
    localparam int PAIR_STATUS = 20;
    localparam int PAIR_MODE   = 26;
    localparam int PAIR_BKR_LO = 13;
    localparam int PAIR_RSV_LO = 27;

    // Values after reset.
    localparam logic [1:0]          CTRL_RST     = 2'h1;
    localparam logic [IVL_W-1:0]    INTERVAL_RST = 16'h03e8;
    localparam logic [SEL_W-1:0]    SEL_RST      = 6'h00;
    localparam logic [DI_CFG_W-1:0] DI_CFG_RST   = 11'h000;

endpackage
